//--- csm_params.svh
`ifndef CSM_PARAMS_SVH
`define CSM_PARAMS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CSM_ADDR_MAIN_CLOCK_CTRL   8'h3a
`define CSM_ADDR_RC_TRIM_UPPER     8'h3b
`define CSM_ADDR_SUPPLY_INTEGRITY  8'h3c
`define CSM_ADDR_THRESH_PRESCALE   8'h3d
`define CSM_ADDR_OSC_SWITCH        8'h51
// ----------------------------------------
// reset values
// ----------------------------------------
`define CSM_RST_MAIN_CLOCK_CTRL    8'h00
`define CSM_RST_RC_TRIM_UPPER      8'hff
`define CSM_RST_TRIM_LOWER         2'h3
`define CSM_RST_THRESH_PRESCALE    8'h00
`define CSM_RST_OSC_SOURCE         1'h1
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSM_BIT_SLOW_SEL           0
`define CSM_BIT_CLKOUT_EN          1
`define CSM_BIT_IRQ_EN             0
`define CSM_BIT_WARN_FLAG          1
`define CSM_BIT_UV_FLAG            2
`define CSM_BIT_WDG_FLAG           4
`define CSM_MSB_TRIM_LOWER         6
`define CSM_LSB_TRIM_LOWER         5
`define CSM_MSB_PRESCALE           7
`define CSM_LSB_PRESCALE           5
`define CSM_MSB_THRESH             1
`define CSM_LSB_THRESH             0
`define CSM_BIT_OSC_SOURCE         0
`define CSM_BIT_RC_READY           2
`define CSM_BIT_WAKEUP_READY       3
// ----------------------------------------
// timing
// ----------------------------------------
`define CSM_SLOW_DIV               32
`endif

//--- csm_pkg.sv
package csm_pkg;
  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } csm_bus_req_t;

  // reset causes arriving from the reset sequencer, one-cycle pulses
  typedef struct packed {
    logic wdg_reset;
    logic uv_reset;
  } csm_reset_cause_t;

  // clock selection outputs
  typedef struct packed {
    logic [9:0] rc_trim;
    logic [2:0] rc_prescale_sel;
    logic [3:0] rc_div_ratio_log2;
    logic       osc_source_sel;
    logic       slow_clock_select;
    logic       clock_output_en;
    logic [1:0] warning_threshold_sel;
    logic       supply_warning_detector_en;
  } csm_clk_ctrl_t;

  // low-power state of the core
  typedef enum logic [1:0] {
    CSM_RUN,
    CSM_WAIT,
    CSM_HALT
  } csm_power_t;
endpackage

//--- csm_clock_supply_regs.sv
`timescale 1ns/10ps
`include "csm_params.svh"
// Functional notes
// - warning flag at integrity bit 1 mirrors comparator live, read only
// - enabled interrupt raised on both rising and falling threshold crossings
// - interrupt enable bit 0 read/write; pending cleared on service entry
// - interrupt reaches cpu only with enable set and global mask clear
// - wait state leaves logic running; warning interrupt wakes from wait
// - halt freezes integrity register except reset-cause flags bits 4 and 2; warning interrupt cannot wake halt
// - threshold bits 1:0 select low, medium, high; 11 turns detector off
// - clock output enable bit 1, reset clear, drives cpu clock to pin
// - slow select bit 0, reset clear, cpu clock is oscillator divided 32
// - ten-bit trim: upper eight reset ones, lower two at integrity 6:5
// - watchdog flag bit 4 set by watchdog reset, cleared by zero or undervoltage
// - undervoltage flag bit 2 set by undervoltage reset, cleared by read
// - undervoltage flag survives later pin or watchdog resets
// - prescaler bits 7:5 divide rc by 2,4,8,16; other codes undivided
// - wake-up oscillator ready flag bit 3 follows oscillator settled status
// - rc oscillator ready flag bit 2 follows oscillator settled status
// - source select bit 0: 0 rc, 1 wake-up oscillator, reset to 1

module csm_clock_supply_regs #(
  parameter int SLOW_DIV = `CSM_SLOW_DIV
) (
  input  wire logic                      clock,
  input  wire logic                      rst,
  input  wire csm_pkg::csm_bus_req_t     bus_req,
  output logic [7:0]                     rdata,
  input  wire csm_pkg::csm_reset_cause_t reset_cause,
  input  wire logic                      supply_below_warning,
  input  wire logic                      wakeup_osc_settled,
  input  wire logic                      rc_osc_settled,
  input  wire csm_pkg::csm_power_t       power_state,
  input  wire logic                      cpu_irq_mask,
  input  wire logic                      irq_service_ack,
  output logic                           irq_req,
  output logic                           wake_req,
  output csm_pkg::csm_clk_ctrl_t         clk_ctrl,
  output logic                           cpu_clock_enable
);
  import csm_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0] main_clock_ctrl;
  logic [7:0] rc_trim_upper;
  logic [1:0] rc_trim_lower_bits;
  logic       watchdog_reset_flag;
  logic       undervoltage_reset_flag;
  logic       supply_warning_flag;
  logic       supply_warning_irq_en;
  logic [2:0] rc_prescale_sel;
  logic [1:0] warning_threshold_sel;
  logic       osc_source_sel;
  logic       wakeup_osc_ready;
  logic       rc_osc_ready;
  logic       warn_prev;
  logic       irq_pending;
  logic [4:0] slow_count;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  wire logic halted     = (power_state == CSM_HALT);
  wire logic sel_main   = (bus_req.addr == `CSM_ADDR_MAIN_CLOCK_CTRL);
  wire logic sel_trim   = (bus_req.addr == `CSM_ADDR_RC_TRIM_UPPER);
  wire logic sel_si     = (bus_req.addr == `CSM_ADDR_SUPPLY_INTEGRITY);
  wire logic sel_thr    = (bus_req.addr == `CSM_ADDR_THRESH_PRESCALE);
  wire logic sel_osc    = (bus_req.addr == `CSM_ADDR_OSC_SWITCH);
  wire logic wr_main    = bus_req.wr && sel_main;
  wire logic wr_trim    = bus_req.wr && sel_trim;
  wire logic wr_si      = bus_req.wr && sel_si && !halted;
  wire logic wr_thr     = bus_req.wr && sel_thr;
  wire logic wr_osc     = bus_req.wr && sel_osc;
  wire logic rd_si      = bus_req.rd && sel_si && !halted;

  // ----------------------------------------
  // read data assembly
  // ----------------------------------------
  wire logic [7:0] si_view = {1'b0, rc_trim_lower_bits, watchdog_reset_flag, 1'b0,
                              undervoltage_reset_flag, supply_warning_flag,
                              supply_warning_irq_en};
  wire logic [7:0] osc_view = {4'h0, wakeup_osc_ready, rc_osc_ready, 1'b0,
                               osc_source_sel};
  wire logic [7:0] next_rdata =
    !bus_req.rd ? 8'h00 :
    sel_main    ? {6'h00, main_clock_ctrl} :
    sel_trim    ? rc_trim_upper :
    sel_si      ? si_view :
    sel_thr     ? {rc_prescale_sel, 3'h0, warning_threshold_sel} :
    sel_osc     ? osc_view : 8'h00;

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // clock control registers
  // ----------------------------------------
  // main clock, trim upper, threshold and oscillator select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_clock_ctrl       <= 2'(`CSM_RST_MAIN_CLOCK_CTRL);
      rc_trim_upper         <= `CSM_RST_RC_TRIM_UPPER;
      rc_prescale_sel       <= 3'h0;
      warning_threshold_sel <= 2'h0;
      osc_source_sel        <= `CSM_RST_OSC_SOURCE;
    end else begin
      if (wr_main)
        main_clock_ctrl <= bus_req.wdata[`CSM_BIT_CLKOUT_EN:`CSM_BIT_SLOW_SEL];
      if (wr_trim)
        rc_trim_upper <= bus_req.wdata;
      if (wr_thr) begin
        rc_prescale_sel       <= bus_req.wdata[`CSM_MSB_PRESCALE:`CSM_LSB_PRESCALE];
        warning_threshold_sel <= bus_req.wdata[`CSM_MSB_THRESH:`CSM_LSB_THRESH];
      end
      if (wr_osc)
        osc_source_sel <= bus_req.wdata[`CSM_BIT_OSC_SOURCE];
    end
  end

  // ----------------------------------------
  // oscillator ready flags, hardware owned
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wakeup_osc_ready <= 1'b1;
      rc_osc_ready     <= 1'b0;
    end else begin
      wakeup_osc_ready <= wakeup_osc_settled;
      rc_osc_ready     <= rc_osc_settled;
    end
  end

  // ----------------------------------------
  // supply integrity register, frozen in halt
  // ----------------------------------------
  wire logic detector_on = (warning_threshold_sel != 2'h3);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rc_trim_lower_bits    <= `CSM_RST_TRIM_LOWER;
      supply_warning_irq_en <= 1'b0;
      supply_warning_flag   <= 1'b0;
    end else if (!halted) begin
      if (wr_si) begin
        rc_trim_lower_bits    <= bus_req.wdata[`CSM_MSB_TRIM_LOWER:`CSM_LSB_TRIM_LOWER];
        supply_warning_irq_en <= bus_req.wdata[`CSM_BIT_IRQ_EN];
      end
      supply_warning_flag <= detector_on && supply_below_warning;
    end
  end

  // reset cause flags: hardware set wins over software clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      watchdog_reset_flag     <= 1'b0;
      undervoltage_reset_flag <= 1'b0;
    end else begin
      if (reset_cause.uv_reset)
        watchdog_reset_flag <= 1'b0;
      else if (reset_cause.wdg_reset)
        watchdog_reset_flag <= 1'b1;
      else if (wr_si && !bus_req.wdata[`CSM_BIT_WDG_FLAG])
        watchdog_reset_flag <= 1'b0;
      if (reset_cause.uv_reset)
        undervoltage_reset_flag <= 1'b1;
      else if (rd_si)
        undervoltage_reset_flag <= 1'b0;
    end
  end

  // ----------------------------------------
  // warning interrupt
  // ----------------------------------------
  wire logic warn_edge = (supply_warning_flag != warn_prev);

  // latch crossings; a new crossing beats the service clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      warn_prev   <= 1'b0;
      irq_pending <= 1'b0;
    end else begin
      warn_prev <= supply_warning_flag;
      if (warn_edge && supply_warning_irq_en)
        irq_pending <= 1'b1;
      else if (irq_service_ack || !supply_warning_irq_en)
        irq_pending <= 1'b0;
    end
  end

  assign irq_req  = irq_pending && !cpu_irq_mask;
  assign wake_req = irq_pending && (power_state == CSM_WAIT);

  // ----------------------------------------
  // slow mode divider
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      slow_count <= 5'h00;
    end else if (slow_count == 5'(SLOW_DIV - 1)) begin
      slow_count <= 5'h00;
    end else begin
      slow_count <= slow_count + 5'h01;
    end
  end

  // one enable per SLOW_DIV clocks in slow mode, every clock otherwise
  assign cpu_clock_enable = !main_clock_ctrl[`CSM_BIT_SLOW_SEL] ||
                            (slow_count == 5'h00);

  // ----------------------------------------
  // clock selection outputs
  // ----------------------------------------
  function automatic logic [3:0] prescale_log2(input logic [2:0] code);
    case (code)
      3'h1:    prescale_log2 = 4'h1;
      3'h2:    prescale_log2 = 4'h2;
      3'h3:    prescale_log2 = 4'h3;
      3'h4:    prescale_log2 = 4'h4;
      default: prescale_log2 = 4'h0;
    endcase
  endfunction

  always_comb begin
    clk_ctrl.rc_trim                    = {rc_trim_upper, rc_trim_lower_bits};
    clk_ctrl.rc_prescale_sel            = rc_prescale_sel;
    clk_ctrl.rc_div_ratio_log2          = prescale_log2(rc_prescale_sel);
    clk_ctrl.osc_source_sel             = osc_source_sel;
    clk_ctrl.slow_clock_select          = main_clock_ctrl[`CSM_BIT_SLOW_SEL];
    clk_ctrl.clock_output_en            = main_clock_ctrl[`CSM_BIT_CLKOUT_EN];
    clk_ctrl.warning_threshold_sel      = warning_threshold_sel;
    clk_ctrl.supply_warning_detector_en = detector_on;
  end
endmodule // csm_clock_supply_regs

//--- csm_clock_supply_regs_checker.sv
`timescale 1ns/10ps
// ------
// checker on the top-level ports
// ------
module csm_clock_supply_regs_checker #(
  parameter int SLOW_DIV = 32
) (
  input wire logic                      clock,
  input wire logic                      rst,
  input wire csm_pkg::csm_bus_req_t     bus_req,
  input wire logic [7:0]                rdata,
  input wire csm_pkg::csm_reset_cause_t reset_cause,
  input wire logic                      supply_below_warning,
  input wire logic                      wakeup_osc_settled,
  input wire logic                      rc_osc_settled,
  input wire csm_pkg::csm_power_t       power_state,
  input wire logic                      cpu_irq_mask,
  input wire logic                      irq_service_ack,
  input wire logic                      irq_req,
  input wire logic                      wake_req,
  input wire csm_pkg::csm_clk_ctrl_t    clk_ctrl,
  input wire logic                      cpu_clock_enable
);
  import csm_pkg::*;
  // one clock domain, async reset
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // interrupt and wake gating
  mask_blocks_irq_a: assert property (cpu_irq_mask |-> !irq_req)
    else $error("irq raised while masked");
  wake_only_wait_a: assert property (wake_req |-> power_state == CSM_WAIT)
    else $error("wake outside wait state");
  // decoded clock controls
  detector_off_a: assert property (clk_ctrl.supply_warning_detector_en ==
    (clk_ctrl.warning_threshold_sel != 2'h3)) else $error("detector enable wrong");
  prescale_ratio_a: assert property (clk_ctrl.rc_div_ratio_log2 ==
    ((clk_ctrl.rc_prescale_sel inside {[3'h1:3'h4]}) ? {1'b0, clk_ctrl.rc_prescale_sel} : 4'h0))
    else $error("prescale ratio wrong");
  fast_clock_en_a: assert property (!clk_ctrl.slow_clock_select |-> cpu_clock_enable)
    else $error("cpu clock gated in normal mode");
  slow_clock_gap_a: assert property (clk_ctrl.slow_clock_select && cpu_clock_enable ##1
    clk_ctrl.slow_clock_select |-> !cpu_clock_enable) else $error("slow enable too dense");
  // register read paths
  trim_readback_a: assert property (bus_req.rd && bus_req.addr == 8'h3b |=>
    rdata == clk_ctrl.rc_trim[9:2]) else $error("trim read wrong");
  main_readback_a: assert property (bus_req.rd && bus_req.addr == 8'h3a |=>
    rdata == {6'h00, clk_ctrl.clock_output_en, clk_ctrl.slow_clock_select})
    else $error("main clock read wrong");
  ready_flags_a: assert property (bus_req.rd && bus_req.addr == 8'h51 |=>
    rdata == {4'h0, $past(wakeup_osc_settled, 2), $past(rc_osc_settled, 2), 1'b0,
    $past(clk_ctrl.osc_source_sel)}) else $error("switch status read wrong");
  idle_rdata_zero_a: assert property (!bus_req.rd |=> rdata == 8'h00)
    else $error("read data outside read slot");
endmodule // csm_clock_supply_regs_checker

bind csm_clock_supply_regs csm_clock_supply_regs_checker #(.SLOW_DIV(SLOW_DIV))
  csm_clock_supply_regs_checker_i (.clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata),
  .reset_cause(reset_cause), .supply_below_warning(supply_below_warning),
  .wakeup_osc_settled(wakeup_osc_settled), .rc_osc_settled(rc_osc_settled),
  .power_state(power_state), .cpu_irq_mask(cpu_irq_mask), .irq_service_ack(irq_service_ack),
  .irq_req(irq_req), .wake_req(wake_req), .clk_ctrl(clk_ctrl),
  .cpu_clock_enable(cpu_clock_enable));

//--- csm_clock_supply_regs_tb_top.sv
`timescale 1ns/10ps
module csm_clock_supply_regs_tb_top;
  import csm_pkg::*;
  localparam int SDIV = 32;
  logic             clock = 1'b0, rst = 1'b1, below = 1'b0, mask = 1'b0, ack = 1'b0;
  logic             wk_set = 1'b1, rc_set = 1'b0, rd_seen = 1'b0;
  logic             irq_req, wake_req, cpu_clock_enable;
  logic [7:0]       rdata, r;
  logic [7:0]       exp_q[$];
  csm_bus_req_t     bus_req = '0;
  csm_reset_cause_t cause = '0;
  csm_power_t       pstate = CSM_RUN;
  csm_clk_ctrl_t    clk_ctrl;
  int               num_errors = 0, n_checks = 0, seed = 32'hf519_1f76, k, cnt;
  logic [7:0]       adr [6] = '{8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h51, 8'h3e};
  logic [7:0]       rstv [6] = '{8'h00, 8'hff, 8'h60, 8'h00, 8'h09, 8'h00};
  // reserved bits kept clear, unmapped 8'h3e written all ones; hardware flag bits written as ones to prove they are ignored
  logic [7:0]       wv [6] = '{8'h03, 8'h00, 8'h77, 8'he3, 8'h0c, 8'hff};
  logic [7:0]       wexp [6] = '{8'h03, 8'h00, 8'h61, 8'he3, 8'h08, 8'h00};

  csm_clock_supply_regs #(.SLOW_DIV(SDIV)) csm_clock_supply_regs_i (
    .clock(clock), .rst(rst), .bus_req(bus_req), .rdata(rdata), .reset_cause(cause),
    .supply_below_warning(below), .wakeup_osc_settled(wk_set), .rc_osc_settled(rc_set),
    .power_state(pstate), .cpu_irq_mask(mask), .irq_service_ack(ack), .irq_req(irq_req),
    .wake_req(wake_req), .clk_ctrl(clk_ctrl), .cpu_clock_enable(cpu_clock_enable));

  // ------
  // helpers
  // ------
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask
  // read strobe, expectation queued for the monitor
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back(e);
    @(posedge clock);
    bus_req.rd <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse_cause(input logic [1:0] c);
    @(posedge clock);
    cause <= c;
    @(posedge clock);
    cause <= 2'b00;
  endtask
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // read data monitor, one cycle after each read strobe
  always @(posedge clock) begin
    if (rd_seen && exp_q.size() > 0) chk({8'h00, rdata}, exp_q.pop_front());
    rd_seen <= bus_req.rd;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    report_and_stop();
  end

  // ------
  // scenarios
  // ------
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (k = 0; k < 6; k++) rd(adr[k], rstv[k]);
    for (k = 0; k < 6; k++) begin
      wr(adr[k], wv[k]);
      rd(adr[k], wexp[k]);
    end
    r = 8'($random(seed));
    wr(8'h3b, r);
    rd(8'h3b, r);
    tick(1);
    chk(clk_ctrl.rc_trim, {r, 2'b11});
    // slow mode is on from the table writes: two enables in two divider periods
    cnt = 0;
    repeat (2 * SDIV) begin
      tick(1);
      cnt += cpu_clock_enable;
    end
    chk(16'(cnt), 16'h0002);
    wr(8'h3a, 8'h02);
    tick(1);
    chk({clk_ctrl.clock_output_en, cpu_clock_enable}, 2'b11);
    for (k = 0; k < 8; k++) begin
      wr(8'h3d, {k[2:0], 3'b000, k[1:0]});
      tick(1);
      chk(clk_ctrl.rc_div_ratio_log2, 16'((k >= 1 && k <= 4) ? k : 0));
      chk(clk_ctrl.supply_warning_detector_en, k[1:0] != 2'b11);
    end
    // warning interrupt on both crossings, ack, mask, wait and halt
    wr(8'h3d, 8'h00);
    wr(8'h3c, 8'h61);
    @(posedge clock) below <= 1'b1;
    tick(2);
    chk(irq_req, 1'b1);
    rd(8'h3c, 8'h63);
    @(posedge clock) ack <= 1'b1;
    @(posedge clock) ack <= 1'b0;
    #1 chk(irq_req, 1'b0);
    @(posedge clock) below <= 1'b0;
    tick(2);
    chk(irq_req, 1'b1);
    @(posedge clock) begin
      mask <= 1'b1;
      pstate <= CSM_WAIT;
    end
    #1 chk({irq_req, wake_req}, 2'b01);
    // pending interrupt survives into halt but must not wake it
    @(posedge clock) begin
      mask <= 1'b0;
      pstate <= CSM_HALT;
      below <= 1'b1;
    end
    #1 chk({irq_req, wake_req}, 2'b10);
    @(posedge clock) ack <= 1'b1;
    @(posedge clock) ack <= 1'b0;
    tick(4);
    chk({irq_req, wake_req}, 2'b00);
    wr(8'h3c, 8'h60);
    rd(8'h3c, 8'h61);
    @(posedge clock) below <= 1'b0;
    @(posedge clock) pstate <= CSM_RUN;
    wr(8'h3c, 8'h60);
    // reset-cause flags: wdg is the upper bit of the cause pulse
    pulse_cause(2'b10);
    rd(8'h3c, 8'h70);
    pulse_cause(2'b01);
    rd(8'h3c, 8'h64);
    rd(8'h3c, 8'h60);
    pulse_cause(2'b01);
    pulse_cause(2'b10);
    rd(8'h3c, 8'h74);
    rd(8'h3c, 8'h70);
    wr(8'h3c, 8'h60);
    rd(8'h3c, 8'h60);
    // oscillator ready flags follow the settled inputs
    @(posedge clock) begin
      wk_set <= 1'b0;
      rc_set <= 1'b1;
    end
    tick(2);
    rd(8'h51, 8'h04);
    tick(3);
    report_and_stop();
  end
endmodule // csm_clock_supply_regs_tb_top
